// ---- shared/actest_pkg.sv ----
package actest_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  FUNC_CTRL_OFS  = 8'h00;
    localparam logic [7:0]  TEST_STAT_OFS  = 8'h04;
    localparam logic [7:0]  ALIGN_OUT_OFS  = 8'h08;
    localparam logic [7:0]  ALIGN_IN_OFS   = 8'h0C;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam int          ALIGN_W        = 8;
    localparam int          CTRL_W         = 8;
    localparam int          ALIGN_UP_LSB   = 0;
    localparam int          ALIGN_DN_LSB   = 8;
    localparam int          STAT_STATE_LSB = 0;
    localparam int          STAT_MODE_BIT  = 2;
    localparam int          STAT_EN_BIT    = 3;
    localparam int          STAT_AC_BIT    = 4;
    localparam int          STAT_LVL_BIT   = 5;
    localparam int          STAT_RXAC_BIT  = 6;
    localparam int          STAT_DRV_BIT   = 7;
    localparam logic [7:0]  FUNC_CTRL_RST  = 8'h00;
    localparam logic [15:0] ALIGN_OUT_RST  = 16'h0000;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          DRV_RST_NS     = 100;
    localparam int          DRV_RST_CYC    = (DRV_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  DRV_RST_LAST   = 3'(DRV_RST_CYC - 1);

    // ************************************************************
    // Test-entry sequence states, Gray along the path
    // ************************************************************
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'h0,
        ST_RESET = 2'h1,
        ST_LOAD  = 2'h3,
        ST_TEST  = 2'h2
    } entry_state_t;

endpackage

// ---- verilog/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync
    import actest_pkg::*;
#(
    parameter int W = 4
)
(
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    // Pins and clean levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t        sync_ff;
    sync_t        nxt_sync;
    logic [W-1:0] q_sel;

    // Level moves once second and third stage agree
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign q_sel[i] = (sync_ff.s2[i] == sync_ff.s3[i]) ? sync_ff.s3[i] : sync_ff.q[i];
    end

    always_comb
    begin
        nxt_sync    = sync_ff;
        nxt_sync.s1 = pin_i;
        nxt_sync.s2 = sync_ff.s1;
        nxt_sync.s3 = sync_ff.s2;
        nxt_sync.q  = q_sel;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            sync_ff <= '0;
        end
        else
        begin
            sync_ff <= nxt_sync;
        end
    end

    assign level_o = sync_ff.q;

endmodule

// ---- verilog/serdes_test_ctrl.sv ----
`timescale 1ns/100ps
module serdes_test_ctrl
    import actest_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_b_i,
    // Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // Boundary-scan test pins
    input  wire logic                scan_mode_i,
    input  wire logic                scan_enable_i,
    input  wire logic                scan_acmode_i,
    input  wire logic                scan_drive_level_select_i,
    // Embedded test controller
    input  wire logic [CTRL_W-1:0]   tc_ctrl_i,
    output logic                     tc_rst_b_o,
    // Physical-medium macro
    output logic      [CTRL_W-1:0]   pma_ctrl_o,
    output logic                     drv_rst_o,
    output logic                     drv_load_o,
    output logic                     rx_ac_mode_o,
    output logic                     drive_level_o,
    // Neighbouring quads
    input  wire logic [ALIGN_W-1:0]  align_in_up_i,
    input  wire logic [ALIGN_W-1:0]  align_in_down_i,
    output logic      [ALIGN_W-1:0]  align_out_up_o,
    output logic      [ALIGN_W-1:0]  align_out_down_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed
    {
        entry_state_t         st;
        logic [2:0]           cnt;
        logic                 ack;
        logic [31:0]          rdat;
        logic [CTRL_W-1:0]    fctrl;
        logic [2*ALIGN_W-1:0] align_out;
        logic [CTRL_W-1:0]    pma;
        logic                 tc_rst_b;
        logic                 rx_ac;
        logic                 drv_lvl;
    } ctl_t;

    ctl_t       ctl_ff;
    ctl_t       nxt_ctl;
    logic [3:0] pins_s;
    logic       mode_s;
    logic       en_s;
    logic       ac_s;
    logic       lvl_s;
    logic       req;
    logic [7:0] stat;

    pin_sync #(.W(4)) u_pin_sync
    (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .pin_i     ({scan_drive_level_select_i, scan_acmode_i, scan_enable_i, scan_mode_i}),
        .level_o   (pins_s)
    );

    assign mode_s = pins_s[0];
    assign en_s   = pins_s[1];
    assign ac_s   = pins_s[2];
    assign lvl_s  = pins_s[3];
    assign req    = cyc_i && stb_i && !ctl_ff.ack;

    always_comb
    begin
        stat                                = 8'h00;
        stat[STAT_STATE_LSB +: 2]           = ctl_ff.st;
        stat[STAT_MODE_BIT]                 = mode_s;
        stat[STAT_EN_BIT]                   = en_s;
        stat[STAT_AC_BIT]                   = ac_s;
        stat[STAT_LVL_BIT]                  = lvl_s;
        stat[STAT_RXAC_BIT]                 = ctl_ff.rx_ac;
        stat[STAT_DRV_BIT]                  = ctl_ff.drv_lvl;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        nxt_ctl = ctl_ff;

        // Bus slave: answer one cycle after request, drop after
        nxt_ctl.ack  = req;
        nxt_ctl.rdat = 32'h0000_0000;
        if (req && we_i)
        begin
            if (adr_i == FUNC_CTRL_OFS && sel_i[0])
            begin
                nxt_ctl.fctrl = dat_i[CTRL_W-1:0];
            end
            if (adr_i == ALIGN_OUT_OFS)
            begin
                if (sel_i[0])
                begin
                    nxt_ctl.align_out[ALIGN_UP_LSB +: ALIGN_W] = dat_i[ALIGN_UP_LSB +: ALIGN_W];
                end
                if (sel_i[1])
                begin
                    nxt_ctl.align_out[ALIGN_DN_LSB +: ALIGN_W] = dat_i[ALIGN_DN_LSB +: ALIGN_W];
                end
            end
        end
        if (req && !we_i)
        begin
            case (adr_i)
                FUNC_CTRL_OFS: nxt_ctl.rdat = {24'h00_0000, ctl_ff.fctrl};
                TEST_STAT_OFS: nxt_ctl.rdat = {24'h00_0000, stat};
                ALIGN_OUT_OFS: nxt_ctl.rdat = {16'h0000, ctl_ff.align_out};
                ALIGN_IN_OFS:  nxt_ctl.rdat = {16'h0000, align_in_down_i, align_in_up_i};
                default:       nxt_ctl.rdat = 32'h0000_0000;
            endcase
        end

        // Macro control multiplexer and controller reset
        nxt_ctl.pma      = mode_s ? tc_ctrl_i : ctl_ff.fctrl;
        nxt_ctl.tc_rst_b = mode_s;

        // Test-entry sequence
        case (ctl_ff.st)
            ST_IDLE:
            begin
                nxt_ctl.cnt = 3'h0;
                if (en_s)
                begin
                    nxt_ctl.st = ST_RESET;
                end
            end
            ST_RESET:
            begin
                nxt_ctl.cnt = ctl_ff.cnt + 3'h1;
                if (ctl_ff.cnt == DRV_RST_LAST)
                begin
                    nxt_ctl.st = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                nxt_ctl.rx_ac   = 1'b0;
                nxt_ctl.drv_lvl = 1'b0;
                nxt_ctl.st      = ST_TEST;
            end
            ST_TEST:
            begin
                if (en_s)
                begin
                    nxt_ctl.rx_ac   = ac_s;
                    nxt_ctl.drv_lvl = lvl_s;
                end
                else
                begin
                    nxt_ctl.st = ST_IDLE;
                end
            end
            default:
            begin
                nxt_ctl.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            ctl_ff           <= '0;
            ctl_ff.st        <= ST_IDLE;
            ctl_ff.fctrl     <= FUNC_CTRL_RST;
            ctl_ff.align_out <= ALIGN_OUT_RST;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign dat_o            = ctl_ff.rdat;
    assign ack_o            = ctl_ff.ack;
    assign tc_rst_b_o       = ctl_ff.tc_rst_b;
    assign pma_ctrl_o       = ctl_ff.pma;
    assign drv_rst_o        = (ctl_ff.st == ST_RESET);
    assign drv_load_o       = (ctl_ff.st == ST_LOAD);
    assign rx_ac_mode_o     = ctl_ff.rx_ac;
    assign drive_level_o    = ctl_ff.drv_lvl;
    assign align_out_up_o   = ctl_ff.align_out[ALIGN_UP_LSB +: ALIGN_W];
    assign align_out_down_o = ctl_ff.align_out[ALIGN_DN_LSB +: ALIGN_W];

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence entry_seq;
        drv_rst_o [*4] ##1 drv_load_o ##1 (!rx_ac_mode_o && !drive_level_o);
    endsequence

    sequence align_wr_seq;
        req && we_i && adr_i == ALIGN_OUT_OFS && sel_i[0];
    endsequence

    test_take_a:   assert property (mode_s |=> pma_ctrl_o == $past(tc_ctrl_i))
        else $error("test controller not routed to macro");
    func_cut_a:    assert property (mode_s && $changed(ctl_ff.fctrl) |=> pma_ctrl_o == $past(tc_ctrl_i))
        else $error("functional control leaked in test mode");
    func_route_a:  assert property (!mode_s |=> pma_ctrl_o == $past(ctl_ff.fctrl))
        else $error("functional control not routed to macro");
    tc_reset_a:    assert property (mode_s != tc_rst_b_o |=> tc_rst_b_o == $past(mode_s))
        else $error("test controller reset not following mode");
    entry_seq_a:   assert property (ctl_ff.st == ST_IDLE && en_s |=> entry_seq)
        else $error("driver reset and load sequence wrong");
    test_default_a: assert property (drv_load_o |=> !rx_ac_mode_o && !drive_level_o)
        else $error("defaults not DC mode and drive zero");
    ac_select_a:   assert property (ctl_ff.st == ST_TEST && en_s |=> rx_ac_mode_o == $past(ac_s))
        else $error("AC/DC select not applied");
    align_write_a: assert property (align_wr_seq |=> align_out_up_o == $past(dat_i[7:0]) && ack_o)
        else $error("alignment output not written");
    hold_idle_a:   assert property (!en_s && ctl_ff.st != ST_RESET && ctl_ff.st != ST_LOAD
                                    |=> $stable(rx_ac_mode_o) && $stable(drive_level_o))
        else $error("settings changed while test disabled");
    bus_ack_a:     assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule

// ---- tb/scan_partner.sv ----
`timescale 1ns/100ps
module scan_partner
    import actest_pkg::*;
(
    // Clock
    input  wire logic               ref_clk_i,
    // Test controller side
    input  wire logic               tc_rst_b_i,
    output logic      [CTRL_W-1:0]  tc_ctrl_o,
    // Neighbouring quads
    input  wire logic [ALIGN_W-1:0] align_out_up_i,
    input  wire logic [ALIGN_W-1:0] align_out_down_i,
    output logic      [ALIGN_W-1:0] align_in_up_o,
    output logic      [ALIGN_W-1:0] align_in_down_o
);
    initial
    begin
        tc_ctrl_o       = 8'h00;
        align_in_up_o   = 8'h00;
        align_in_down_o = 8'h00;
    end

    // Controller idles at zero in reset, fixed pattern once released
    always @(posedge ref_clk_i)
    begin
        tc_ctrl_o       <= tc_rst_b_i ? 8'h96 : 8'h00;
        align_in_up_o   <= align_out_up_i ^ 8'hA5;
        align_in_down_o <= align_out_down_i ^ 8'h5A;
    end
endmodule

// ---- tb/tb_serdes_test_ctrl.sv ----
`timescale 1ns/100ps
module tb_serdes_test_ctrl
    import actest_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, tc_rst_b_o, drv_rst_o, drv_load_o, rx_ac_mode_o, drive_level_o;
    logic scan_mode_i = 1'b0, scan_enable_i = 1'b0, scan_acmode_i = 1'b0, scan_lvl = 1'b0;
    logic [7:0] tc_ctrl_i, pma_ctrl_o, in_up, in_dn, out_up, out_dn;
    int n_mismatch = 0;
    int checked = 0;
    int n;

    initial
    begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    serdes_test_ctrl i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .scan_mode_i(scan_mode_i), .scan_enable_i(scan_enable_i), .scan_acmode_i(scan_acmode_i),
        .scan_drive_level_select_i(scan_lvl), .tc_ctrl_i(tc_ctrl_i), .tc_rst_b_o(tc_rst_b_o),
        .pma_ctrl_o(pma_ctrl_o), .drv_rst_o(drv_rst_o), .drv_load_o(drv_load_o),
        .rx_ac_mode_o(rx_ac_mode_o), .drive_level_o(drive_level_o), .align_in_up_i(in_up),
        .align_in_down_i(in_dn), .align_out_up_o(out_up), .align_out_down_o(out_dn));

    scan_partner i_partner (.ref_clk_i(ref_clk_i), .tc_rst_b_i(tc_rst_b_o), .tc_ctrl_o(tc_ctrl_i),
        .align_out_up_i(out_up), .align_out_down_i(out_dn), .align_in_up_o(in_up),
        .align_in_down_o(in_dn));

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ************************************************************
    // Wishbone classic single cycle
    // ************************************************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int t;
        @(posedge ref_clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        for (t = 0; t < 20; t++)
        begin
            @(posedge ref_clk_i);
            if (ack_o === 1'b1)
                break;
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (t == 20)
        begin
            n_mismatch++;
            summarize();
        end
    endtask

    task automatic pins(input logic m, input logic e, input logic ac, input logic lv, input int cyc);
        @(posedge ref_clk_i);
        scan_mode_i   <= m;
        scan_enable_i <= e;
        scan_acmode_i <= ac;
        scan_lvl      <= lv;
        repeat (cyc) @(negedge ref_clk_i);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(negedge ref_clk_i);
        chk("tc_rst_b reset", tc_rst_b_o, 1'b0);
        wb(1'b0, FUNC_CTRL_OFS, 4'hF, 32'h0);
        chk("func_ctrl reset", rd, 32'(FUNC_CTRL_RST));
        wb(1'b0, ALIGN_OUT_OFS, 4'hF, 32'h0);
        chk("align_out reset", rd, 32'(ALIGN_OUT_RST));
        wb(1'b1, FUNC_CTRL_OFS, 4'h1, 32'hFFFF_FF3C);
        wb(1'b0, 8'h10, 4'hF, 32'h0);
        chk("unmapped read", rd, 32'h0);
        @(negedge ref_clk_i);
        chk("pma functional", pma_ctrl_o, 8'h3C);
        pins(1'b1, 1'b0, 1'b0, 1'b0, 8);
        chk("tc_rst_b released", tc_rst_b_o, 1'b1);
        chk("pma test path", pma_ctrl_o, 8'h96);
        wb(1'b1, FUNC_CTRL_OFS, 4'h1, 32'h0000_00C3);
        repeat (2) @(negedge ref_clk_i);
        chk("pma isolated", pma_ctrl_o, 8'h96);
        pins(1'b0, 1'b0, 1'b0, 1'b0, 8);
        chk("tc_rst_b held", tc_rst_b_o, 1'b0);
        chk("pma back", pma_ctrl_o, 8'hC3);
        pins(1'b0, 1'b1, 1'b1, 1'b1, 0);
        for (n = 0; n < 20 && drv_rst_o !== 1'b1; n++)
            @(negedge ref_clk_i);
        for (n = 0; n < 20 && drv_rst_o === 1'b1; n++)
            @(negedge ref_clk_i);
        chk("drv_rst length", 32'(n), 32'(DRV_RST_CYC));
        chk("drv_load after reset", drv_load_o, 1'b1);
        @(negedge ref_clk_i);
        chk("drv_load pulse", drv_load_o, 1'b0);
        chk("rx default dc", rx_ac_mode_o, 1'b0);
        chk("tx default zero", drive_level_o, 1'b0);
        repeat (3) @(negedge ref_clk_i);
        chk("ac selected", rx_ac_mode_o, 1'b1);
        chk("level followed", drive_level_o, 1'b1);
        pins(1'b0, 1'b1, 1'b0, 1'b1, 6);
        chk("dc selected", rx_ac_mode_o, 1'b0);
        pins(1'b0, 1'b0, 1'b0, 1'b1, 6);
        pins(1'b0, 1'b0, 1'b1, 1'b0, 6);
        chk("rx held", rx_ac_mode_o, 1'b0);
        chk("tx held", drive_level_o, 1'b1);
        wb(1'b0, TEST_STAT_OFS, 4'hF, 32'h0);
        chk("state idle", rd[1:0], ST_IDLE);
        wb(1'b1, ALIGN_OUT_OFS, 4'h3, 32'h0000_9A5E);
        wb(1'b1, ALIGN_OUT_OFS, 4'h2, 32'h0000_3311);
        @(negedge ref_clk_i);
        chk("align up out", out_up, 8'h5E);
        chk("align down out", out_dn, 8'h33);
        wb(1'b0, ALIGN_IN_OFS, 4'hF, 32'h0);
        chk("align in", rd[15:0], {8'h33 ^ 8'h5A, 8'h5E ^ 8'hA5});
        summarize();
    end

    initial
    begin
        #100us;
        n_mismatch++;
        summarize();
    end
endmodule
